// [logic/pbc_pkg.sv]
// Constants and types shared by the basic control register block
package pbc_pkg;
    // Register map
    localparam logic [4:0]  PBC_REG_BASIC_CONTROL = 5'h00;
    // Field positions of basic_control
    localparam int          PBC_BIT_RESET         = 15;
    localparam int          PBC_BIT_LOOPBACK      = 14;
    localparam int          PBC_BIT_RATE          = 13;
    localparam int          PBC_BIT_AN_ENABLE     = 12;
    localparam int          PBC_BIT_LOW_POWER     = 11;
    localparam int          PBC_BIT_ISOLATE       = 10;
    localparam int          PBC_BIT_AN_RESTART    = 9;
    localparam int          PBC_BIT_DUPLEX        = 8;
    localparam int          PBC_BIT_COL_TEST      = 7;
    // Reset values
    localparam logic [15:0] PBC_CTRL_RESET_VALUE  = 16'h3000;
    localparam logic [15:0] PBC_READ_IN_RESET     = 16'h8000;
    localparam logic [15:0] PBC_READ_UNMAPPED     = 16'h0000;
    localparam logic [6:0]  PBC_RESERVED_VALUE    = 7'h00;
    localparam logic [4:0]  PBC_ISOLATE_ADDR      = 5'h00;
    // Timing
    localparam int          PBC_CLK_PERIOD_NS     = 20;
    localparam int          PBC_SW_RESET_NS       = 1000;
    localparam int          PBC_SW_RESET_CYCLES   =
        (PBC_SW_RESET_NS + PBC_CLK_PERIOD_NS - 1) / PBC_CLK_PERIOD_NS;
    localparam logic [5:0]  PBC_SW_RESET_LAST     = 6'(PBC_SW_RESET_CYCLES - 1);
    // Bit time at 100 Mbps is the tighter of the two rates
    localparam int          PBC_BIT_TIME_NS       = 10;
    localparam int          PBC_COL_ON_BITS       = 512;
    localparam int          PBC_COL_OFF_BITS      = 4;
    localparam int          PBC_COL_ON_CYCLES     =
        PBC_COL_ON_BITS * PBC_BIT_TIME_NS / PBC_CLK_PERIOD_NS;
    localparam int          PBC_COL_OFF_CYCLES    =
        PBC_COL_OFF_BITS * PBC_BIT_TIME_NS / PBC_CLK_PERIOD_NS;

    // Software reset sequencer
    typedef enum logic [1:0] {
        PBC_IDLE  = 2'b00,
        PBC_SWRST = 2'b01
    } pbc_rst_state_t;
endpackage : pbc_pkg

// [logic/pbc_mac_path.sv]
// MAC-side data path: loopback, collision test, isolate and low power
`timescale 1ns/1ps
module pbc_mac_path
    import pbc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       loopback_in,
    input  wire logic       col_test_in,
    input  wire logic       isolate_in,
    input  wire logic       low_power_in,
    input  wire logic       hold_in,
    input  wire logic       tx_en_in,
    input  wire logic [3:0] txd_in,
    input  wire logic       tx_er_in,
    input  wire logic       line_rx_dv_in,
    input  wire logic [3:0] line_rxd_in,
    input  wire logic       line_rx_er_in,
    input  wire logic       line_col_in,
    input  wire logic       line_crs_in,
    output logic            line_tx_en_out,
    output logic [3:0]      line_txd_out,
    output logic            line_tx_er_out,
    output logic            rx_dv_out,
    output logic [3:0]      rxd_out,
    output logic            rx_er_out,
    output logic            col_out,
    output logic            crs_out,
    output logic            mac_oe_n_out
);
    logic [5:0] tx_meta;
    logic [5:0] tx_sync;
    logic       tx_en_s;
    logic       path_on;

    // Two-stage synchroniser for the MAC transmit pins
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tx_meta <= 6'h00;
            tx_sync <= 6'h00;
        end else begin
            tx_meta <= {tx_er_in, tx_en_in, txd_in};
            tx_sync <= tx_meta;
        end
    end

    assign tx_en_s = tx_sync[4];
    // Inputs ignored while isolated, powered down or held in reset
    assign path_on = !isolate_in && !low_power_in && !hold_in; // [RULE11] [RULE1]

    // Outputs and line transmit, all registered
    always_ff @(posedge clk_in) begin
        if (!rstn_in || !path_on) begin
            line_tx_en_out <= 1'b0; // [RULE9]
            line_txd_out   <= 4'h0;
            line_tx_er_out <= 1'b0;
            rx_dv_out      <= 1'b0;
            rxd_out        <= 4'h0;
            rx_er_out      <= 1'b0;
            col_out        <= 1'b0;
            crs_out        <= 1'b0;
        end else if (loopback_in) begin
            line_tx_en_out <= 1'b0; // [RULE3]
            line_txd_out   <= 4'h0;
            line_tx_er_out <= 1'b0;
            rx_dv_out      <= tx_en_s; // [RULE3] [RULE4]
            rxd_out        <= tx_sync[3:0];
            rx_er_out      <= tx_sync[5];
            crs_out        <= tx_en_s;
            col_out        <= col_test_in && tx_en_s; // [RULE16] [RULE17]
        end else begin
            line_tx_en_out <= tx_en_s;
            line_txd_out   <= tx_sync[3:0];
            line_tx_er_out <= tx_sync[5];
            rx_dv_out      <= line_rx_dv_in;
            rxd_out        <= line_rxd_in;
            rx_er_out      <= line_rx_er_in;
            crs_out        <= line_crs_in;
            col_out        <= col_test_in ? tx_en_s : line_col_in; // [RULE16]
        end
    end

    // Output enable high releases the MAC outputs
    assign mac_oe_n_out = isolate_in; // [RULE11]

    default clocking pbc_mp_cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_loop_rx_dv: assert property (loopback_in && path_on && $rose(tx_en_s)
        |-> ##[1:256] rx_dv_out) // [RULE4]
        else $error("loopback rx_dv late");
    a_loop_line_quiet: assert property (loopback_in |=> !line_tx_en_out) // [RULE3]
        else $error("line transmit active in loopback");
    a_coltest_rise: assert property (col_test_in && path_on && $rose(tx_en_s)
        ##1 (col_test_in && path_on)[*1] |-> col_out) // [RULE16]
        else $error("collision test col late");
    a_coltest_fall: assert property (col_test_in && $fell(tx_en_s)
        |-> ##[1:2] !col_out) // [RULE16]
        else $error("collision test col not released");
    a_no_coltest: assert property (!col_test_in && loopback_in |=> !col_out) // [RULE17]
        else $error("col follows tx_en without test");
    a_low_power_low: assert property (low_power_in |=> !rx_dv_out && !crs_out
        && !col_out && rxd_out == 4'h0) // [RULE9]
        else $error("MAC outputs not low in low power");
    a_isolate_ignore: assert property (isolate_in |=> !line_tx_en_out && !rx_dv_out) // [RULE11]
        else $error("inputs not ignored when isolated");

    c_loop_frame: cover property (loopback_in && rx_dv_out ##1 !rx_dv_out);
    c_coltest: cover property (col_test_in && col_out ##[1:2] !col_out);
endmodule : pbc_mac_path

// [logic/pbc_basic_control.sv]
// Basic control register of a 10/100 PHY with strap overrides
`timescale 1ns/1ps
// Contract
// RULE1: Reset bit restores defaults, idles machines
// RULE2: Reset bit reads one, accesses blocked
// RULE3: Loopback disables line, loops MAC data
// RULE4: Loopback RX_DV within 512 bit times
// RULE5: Hardware mode takes rate from strap
// RULE6: Manual rate bit; negotiation result otherwise
// RULE7: Hardware mode takes negotiation enable strap
// RULE8: Negotiation enable overrides rate and duplex; in hardware mode the straps still set rate and duplex
// RULE9: Low power drives MAC outputs low
// RULE10: Low power entry clears latching bits only
// RULE11: Isolate releases MAC outputs, ignores inputs
// RULE12: Isolate default one at address zero
// RULE13: Restart ignored unless negotiation; self clears
// RULE14: Hardware mode takes duplex from strap
// RULE15: Duplex bit manual; ignored in loopback
// RULE16: Collision test COL follows TX_EN
// RULE17: No collision test, COL independent
// RULE18: Seven low reserved bits read zero
// RULE19: Manager writes reserved bits as default
// RULE20: Self clearing bits start and clear
// RULE21: Latching high holds until read
// RULE22: Rate and negotiation enable default one
module pbc_basic_control
    import pbc_pkg::*;
(
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic [4:0]  MGMT_ADDR_IN,
    input  wire logic        MGMT_WR_IN,
    input  wire logic        MGMT_RD_IN,
    input  wire logic [15:0] MGMT_WDATA_IN,
    output logic [15:0]      MGMT_RDATA_OUT,
    output logic             MGMT_BUSY_OUT,
    input  wire logic        STATUS_RD_IN,
    input  wire logic        HARDWARE_SOFTWARE_STRAP_IN,
    input  wire logic        RATE_STRAP_PIN_IN,
    input  wire logic        AUTONEG_STRAP_PIN_IN,
    input  wire logic        DUPLEX_STRAP_PIN_IN,
    input  wire logic [4:0]  PHY_ADDR_IN,
    input  wire logic        AN_RATE_IN,
    input  wire logic        AN_DUPLEX_IN,
    input  wire logic        LINK_UP_IN,
    input  wire logic        JABBER_IN,
    output logic             AN_ENABLE_OUT,
    output logic             AN_RESTART_OUT,
    output logic             SM_RESET_OUT,
    output logic             RATE_100_OUT,
    output logic             FULL_DUPLEX_OUT,
    output logic             LINK_LATCHING_LOW_OUT,
    output logic             JABBER_LATCHING_HIGH_OUT,
    output logic             LOW_POWER_OUT,
    output logic             LINE_TX_ENABLE_OUT,
    output logic             LINE_RX_ENABLE_OUT,
    output logic             COL_DETECT_ENABLE_OUT,
    output logic             LINE_TRANSMIT_TRISTATE_N_OUT,
    input  wire logic        TX_EN_IN,
    input  wire logic [3:0]  TXD_IN,
    input  wire logic        TX_ER_IN,
    input  wire logic        LINE_RX_DV_IN,
    input  wire logic [3:0]  LINE_RXD_IN,
    input  wire logic        LINE_RX_ER_IN,
    input  wire logic        LINE_COL_IN,
    input  wire logic        LINE_CRS_IN,
    output logic             LINE_TX_EN_OUT,
    output logic [3:0]       LINE_TXD_OUT,
    output logic             LINE_TX_ER_OUT,
    output logic             RX_DV_OUT,
    output logic [3:0]       RXD_OUT,
    output logic             RX_ER_OUT,
    output logic             COL_OUT,
    output logic             CRS_OUT,
    output logic             MAC_OE_N_OUT
);
    logic [8:0]     strap_meta;
    logic [8:0]     strap_sync;
    logic           hw_mode;
    logic           strap_rate;
    logic           strap_an;
    logic           strap_duplex;
    logic [4:0]     strap_addr;
    pbc_rst_state_t rst_state;
    pbc_rst_state_t next_rst_state;
    logic [5:0]     rst_cnt;
    logic           sw_busy;
    logic           reg_hit;
    logic           reg_write;
    logic           sw_start;
    logic           loopback;
    logic           rate_sel;
    logic           an_en_bit;
    logic           low_power;
    logic           low_power_q;
    logic           lp_rise;
    logic           isolate;
    logic           an_restart;
    logic           duplex_bit;
    logic           col_test;
    logic           an_enable_eff;
    logic           an_enable_wr;
    logic [15:0]    ctrl_word;

    // Strap pins cross two flip-flops before use; free running so the
    // strapped address has settled before the reset defaults load
    always_ff @(posedge SYS_CLK_IN) begin
        strap_meta <= {HARDWARE_SOFTWARE_STRAP_IN, RATE_STRAP_PIN_IN,
                       AUTONEG_STRAP_PIN_IN, DUPLEX_STRAP_PIN_IN, PHY_ADDR_IN};
        strap_sync <= strap_meta;
    end

    assign hw_mode      = !strap_sync[8];
    assign strap_rate   = strap_sync[7];
    assign strap_an     = strap_sync[6];
    assign strap_duplex = strap_sync[5];
    assign strap_addr   = strap_sync[4:0];

    // Access decode; writes blocked during software reset
    assign reg_hit   = (MGMT_ADDR_IN == PBC_REG_BASIC_CONTROL);
    assign reg_write = MGMT_WR_IN && reg_hit && !sw_busy; // [RULE2]
    assign sw_start  = reg_write && MGMT_WDATA_IN[PBC_BIT_RESET]; // [RULE20]
    assign sw_busy   = (rst_state == PBC_SWRST);

    // Software reset sequencer next state
    always_comb begin
        next_rst_state = rst_state;
        case (rst_state)
            PBC_IDLE: begin
                if (sw_start) begin
                    next_rst_state = PBC_SWRST; // [RULE1]
                end
            end
            PBC_SWRST: begin
                if (rst_cnt == PBC_SW_RESET_LAST) begin
                    next_rst_state = PBC_IDLE; // [RULE2] [RULE20]
                end
            end
            default: begin
                next_rst_state = PBC_IDLE;
            end
        endcase
    end

    // Sequencer state and duration counter
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            rst_state <= PBC_IDLE;
            rst_cnt   <= 6'h00;
        end else begin
            rst_state <= next_rst_state;
            rst_cnt   <= sw_busy ? rst_cnt + 6'h01 : 6'h00;
        end
    end

    // Control bits; defaults reload for the whole reset
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN || sw_busy) begin
            loopback   <= PBC_CTRL_RESET_VALUE[PBC_BIT_LOOPBACK]; // [RULE1]
            rate_sel   <= PBC_CTRL_RESET_VALUE[PBC_BIT_RATE]; // [RULE22]
            an_en_bit  <= PBC_CTRL_RESET_VALUE[PBC_BIT_AN_ENABLE]; // [RULE22]
            low_power  <= PBC_CTRL_RESET_VALUE[PBC_BIT_LOW_POWER];
            isolate    <= (strap_addr == PBC_ISOLATE_ADDR); // [RULE12]
            duplex_bit <= PBC_CTRL_RESET_VALUE[PBC_BIT_DUPLEX];
            col_test   <= PBC_CTRL_RESET_VALUE[PBC_BIT_COL_TEST];
        end else if (reg_write && !MGMT_WDATA_IN[PBC_BIT_RESET]) begin
            loopback   <= MGMT_WDATA_IN[PBC_BIT_LOOPBACK];
            rate_sel   <= MGMT_WDATA_IN[PBC_BIT_RATE];
            an_en_bit  <= MGMT_WDATA_IN[PBC_BIT_AN_ENABLE];
            low_power  <= MGMT_WDATA_IN[PBC_BIT_LOW_POWER];
            isolate    <= MGMT_WDATA_IN[PBC_BIT_ISOLATE];
            duplex_bit <= MGMT_WDATA_IN[PBC_BIT_DUPLEX];
            col_test   <= MGMT_WDATA_IN[PBC_BIT_COL_TEST];
        end
    end

    // Effective negotiation enable: strap in hardware mode
    assign an_enable_eff = hw_mode ? strap_an : an_en_bit; // [RULE7] [RULE8]
    // Enable as it stands once the current write lands
    assign an_enable_wr  = hw_mode ? strap_an : MGMT_WDATA_IN[PBC_BIT_AN_ENABLE]; // [RULE13]

    // Restart pulses one cycle, only with negotiation on
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN || sw_busy) begin
            an_restart <= 1'b0;
        end else begin
            an_restart <= reg_write && MGMT_WDATA_IN[PBC_BIT_AN_RESTART]
                          && an_enable_wr; // [RULE13] [RULE20]
        end
    end

    // Resolved rate and duplex
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN || sw_busy) begin
            RATE_100_OUT    <= PBC_CTRL_RESET_VALUE[PBC_BIT_RATE];
            FULL_DUPLEX_OUT <= PBC_CTRL_RESET_VALUE[PBC_BIT_DUPLEX];
        end else begin
            if (hw_mode) begin
                RATE_100_OUT <= strap_rate; // [RULE5]
            end else if (an_enable_eff) begin
                RATE_100_OUT <= AN_RATE_IN; // [RULE6] [RULE8]
            end else begin
                RATE_100_OUT <= rate_sel; // [RULE6]
            end
            if (hw_mode) begin
                FULL_DUPLEX_OUT <= strap_duplex; // [RULE14]
            end else if (loopback) begin
                FULL_DUPLEX_OUT <= 1'b1; // [RULE15]
            end else if (an_enable_eff) begin
                FULL_DUPLEX_OUT <= AN_DUPLEX_IN; // [RULE8]
            end else begin
                FULL_DUPLEX_OUT <= duplex_bit; // [RULE15]
            end
        end
    end

    // Latching status bits, reinitialised on low power entry
    assign lp_rise = low_power && !low_power_q;
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN || sw_busy || lp_rise) begin
            low_power_q              <= low_power;
            LINK_LATCHING_LOW_OUT    <= 1'b0; // [RULE10]
            JABBER_LATCHING_HIGH_OUT <= 1'b0; // [RULE10]
        end else begin
            low_power_q <= low_power;
            if (STATUS_RD_IN) begin
                LINK_LATCHING_LOW_OUT    <= LINK_UP_IN;
                JABBER_LATCHING_HIGH_OUT <= JABBER_IN; // [RULE21]
            end else begin
                LINK_LATCHING_LOW_OUT    <= LINK_LATCHING_LOW_OUT && LINK_UP_IN;
                JABBER_LATCHING_HIGH_OUT <= JABBER_LATCHING_HIGH_OUT || JABBER_IN; // [RULE21]
            end
        end
    end

    // Read image; reserved bits are zero
    assign ctrl_word = {1'b0, loopback, rate_sel, an_en_bit, low_power, isolate,
                        an_restart, duplex_bit, col_test, PBC_RESERVED_VALUE}; // [RULE18]

    // Read data register
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            MGMT_RDATA_OUT <= PBC_READ_UNMAPPED;
        end else if (MGMT_RD_IN) begin
            if (sw_busy) begin
                MGMT_RDATA_OUT <= PBC_READ_IN_RESET; // [RULE2]
            end else if (reg_hit) begin
                MGMT_RDATA_OUT <= ctrl_word;
            end else begin
                MGMT_RDATA_OUT <= PBC_READ_UNMAPPED;
            end
        end
    end

    // Control outputs to the rest of the PHY
    assign MGMT_BUSY_OUT                = sw_busy;
    assign SM_RESET_OUT                 = sw_busy; // [RULE1]
    assign AN_ENABLE_OUT                = an_enable_eff;
    assign AN_RESTART_OUT               = an_restart;
    assign LOW_POWER_OUT                = low_power; // [RULE9]
    assign LINE_TX_ENABLE_OUT           = !loopback && !low_power; // [RULE3]
    assign LINE_RX_ENABLE_OUT           = !loopback && !low_power; // [RULE3]
    assign COL_DETECT_ENABLE_OUT        = !low_power && (!loopback || col_test); // [RULE3]
    assign LINE_TRANSMIT_TRISTATE_N_OUT = low_power || loopback; // [RULE9]

    // MAC-side data path
    pbc_mac_path u_mac_path (
        .clk_in         (SYS_CLK_IN),
        .rstn_in        (RSTN_IN),
        .loopback_in    (loopback),
        .col_test_in    (col_test),
        .isolate_in     (isolate),
        .low_power_in   (low_power),
        .hold_in        (sw_busy),
        .tx_en_in       (TX_EN_IN),
        .txd_in         (TXD_IN),
        .tx_er_in       (TX_ER_IN),
        .line_rx_dv_in  (LINE_RX_DV_IN),
        .line_rxd_in    (LINE_RXD_IN),
        .line_rx_er_in  (LINE_RX_ER_IN),
        .line_col_in    (LINE_COL_IN),
        .line_crs_in    (LINE_CRS_IN),
        .line_tx_en_out (LINE_TX_EN_OUT),
        .line_txd_out   (LINE_TXD_OUT),
        .line_tx_er_out (LINE_TX_ER_OUT),
        .rx_dv_out      (RX_DV_OUT),
        .rxd_out        (RXD_OUT),
        .rx_er_out      (RX_ER_OUT),
        .col_out        (COL_OUT),
        .crs_out        (CRS_OUT),
        .mac_oe_n_out   (MAC_OE_N_OUT)
    );

    default clocking pbc_cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    a_swrst_length: assert property (sw_start |-> ##1 MGMT_BUSY_OUT [*8]
        ##42 MGMT_BUSY_OUT ##1 !MGMT_BUSY_OUT) // [RULE2]
        else $error("software reset length wrong");
    a_swrst_reads_one: assert property (MGMT_BUSY_OUT && MGMT_RD_IN
        |=> MGMT_RDATA_OUT == PBC_READ_IN_RESET) // [RULE2]
        else $error("reset bit not read as one");
    a_swrst_defaults: assert property ($fell(MGMT_BUSY_OUT) |-> rate_sel && an_en_bit
        && !loopback && !low_power && !col_test && !duplex_bit) // [RULE1] [RULE22]
        else $error("defaults not restored");
    a_restart_ignored: assert property (reg_write && !an_enable_wr
        |=> !AN_RESTART_OUT) // [RULE13]
        else $error("restart taken with negotiation off");
    a_restart_clears: assert property (AN_RESTART_OUT |=> !AN_RESTART_OUT) // [RULE20]
        else $error("restart bit did not clear");
    a_rate_hw_strap: assert property (hw_mode && !sw_busy
        |=> RATE_100_OUT == $past(strap_rate)) // [RULE5]
        else $error("rate not from strap");
    a_rate_sw_manual: assert property (!hw_mode && !an_en_bit && !sw_busy
        |=> RATE_100_OUT == $past(rate_sel)) // [RULE6]
        else $error("rate not from rate bit");
    a_duplex_hw_strap: assert property (hw_mode && !sw_busy
        |=> FULL_DUPLEX_OUT == $past(strap_duplex)) // [RULE14]
        else $error("duplex not from strap");
    a_an_hw_strap: assert property (hw_mode |-> AN_ENABLE_OUT == strap_an) // [RULE7]
        else $error("negotiation enable not from strap");
    a_reserved_zero: assert property (MGMT_RD_IN && reg_hit && !sw_busy
        |=> MGMT_RDATA_OUT[6:0] == 7'h00) // [RULE18]
        else $error("reserved bits not zero");
    a_isolate_default: assert property ($rose(RSTN_IN)
        |-> isolate == (strap_addr == PBC_ISOLATE_ADDR)) // [RULE12]
        else $error("isolate default wrong");
    a_lp_latch_clear: assert property (lp_rise |=> !JABBER_LATCHING_HIGH_OUT
        && !LINK_LATCHING_LOW_OUT) // [RULE10]
        else $error("latching bits kept on low power");
    a_lh_hold: assert property (JABBER_LATCHING_HIGH_OUT && !STATUS_RD_IN
        && !lp_rise && !sw_busy |=> JABBER_LATCHING_HIGH_OUT) // [RULE21]
        else $error("latching high bit dropped");

    c_sw_reset: cover property (sw_start ##1 MGMT_BUSY_OUT);
    c_an_restart: cover property (AN_RESTART_OUT);
endmodule : pbc_basic_control

// [dv/pbc_mac_model.sv]
// MAC-side partner that sends a transmit burst on request
`timescale 1ns/1ps
module pbc_mac_model (
    input  wire logic  clk_in,
    input  wire logic  go_in,
    output logic       tx_en_out,
    output logic [3:0] txd_out,
    output logic       tx_er_out
);
    // Idle at time zero
    initial begin
        tx_en_out = 1'b0;
        txd_out   = 4'h0;
        tx_er_out = 1'b0;
    end
    // Counting nibbles in a burst, toggling data when idle
    always @(posedge clk_in) begin
        tx_en_out <= #1 go_in;
        txd_out   <= #1 go_in ? txd_out + 4'h1 : ~txd_out;
        tx_er_out <= #1 1'b0;
    end
endmodule : pbc_mac_model

// [dv/tb_top.sv]
// Self-checking bench for the basic control register block
`timescale 1ns/1ps
module tb_top;
    logic        clk  = 1'b0;
    logic        rstn = 1'b0;
    logic        wr   = 1'b0;
    logic        rd   = 1'b0;
    logic        hws  = 1'b1;
    logic        go   = 1'b0;
    logic        srd  = 1'b0;
    logic [4:0]  pad  = 5'h00;
    logic        jab  = 1'b0;
    logic [2:0]  strp = 3'h7;
    logic [1:0]  anr  = 2'h0;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wd   = 16'h0000;
    int          errors      = 0;
    int          comparisons = 0;
    wire  [15:0] rdata;
    wire  [6:0]  mon;
    wire  [3:0]  txd;
    wire         txen, txer, rate, fdx, ltxe, lrxe, ltri, llo;

    // Clock at 50 MHz
    always #10 clk = ~clk;

    pbc_mac_model u_mac (.clk_in(clk), .go_in(go), .tx_en_out(txen), .txd_out(txd),
        .tx_er_out(txer));

    pbc_basic_control u_dut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .MGMT_ADDR_IN(addr),
        .MGMT_WR_IN(wr), .MGMT_RD_IN(rd), .MGMT_WDATA_IN(wd), .MGMT_RDATA_OUT(rdata),
        .MGMT_BUSY_OUT(mon[4]), .STATUS_RD_IN(srd), .HARDWARE_SOFTWARE_STRAP_IN(hws),
        .RATE_STRAP_PIN_IN(strp[2]), .AUTONEG_STRAP_PIN_IN(strp[1]),
        .DUPLEX_STRAP_PIN_IN(strp[0]), .PHY_ADDR_IN(pad), .AN_RATE_IN(anr[1]),
        .AN_DUPLEX_IN(anr[0]), .LINK_UP_IN(1'b1), .JABBER_IN(jab), .AN_ENABLE_OUT(mon[0]),
        .AN_RESTART_OUT(mon[1]), .SM_RESET_OUT(), .RATE_100_OUT(rate),
        .FULL_DUPLEX_OUT(fdx), .LINK_LATCHING_LOW_OUT(llo), .JABBER_LATCHING_HIGH_OUT(mon[6]),
        .LOW_POWER_OUT(), .LINE_TX_ENABLE_OUT(ltxe), .LINE_RX_ENABLE_OUT(lrxe),
        .COL_DETECT_ENABLE_OUT(), .LINE_TRANSMIT_TRISTATE_N_OUT(ltri), .TX_EN_IN(txen),
        .TXD_IN(txd), .TX_ER_IN(txer), .LINE_RX_DV_IN(jab), .LINE_RXD_IN(~txd),
        .LINE_RX_ER_IN(jab), .LINE_COL_IN(jab), .LINE_CRS_IN(jab), .LINE_TX_EN_OUT(),
        .LINE_TXD_OUT(), .LINE_TX_ER_OUT(), .RX_DV_OUT(mon[2]), .RXD_OUT(), .RX_ER_OUT(),
        .COL_OUT(mon[3]), .CRS_OUT(), .MAC_OE_N_OUT(mon[5]));

    task automatic report_and_stop;
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: read %h, want %h", $time, g, e);
        end
    endtask : chk16

    task automatic chk1(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: flag %b, want %b", $time, g, e);
        end
    endtask : chk1

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask : step

    // Bounded wait on one monitored output
    task automatic wait_bit(input int i, input logic v, input int n);
        int k;
        k = 0;
        while (mon[i] !== v && k < n) begin
            step(1);
            k++;
        end
        chk1(mon[i], v);
        if (mon[i] !== v) begin
            report_and_stop();
        end
    endtask : wait_bit

    task automatic wr_reg(input logic [15:0] d);
        addr = 5'h00;
        wd   = d;
        wr   = 1'b1;
        step(1);
        wr   = 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        addr = a;
        rd   = 1'b1;
        step(1);
        rd   = 1'b0;
        step(1);
        chk16(rdata, e);
    endtask : rd_chk

    // Main sequence
    initial begin
        step(16);
        rstn = 1'b1;
        rd_chk(5'h00, 16'h3400);
        rd_chk(5'h03, 16'h0000);
        wr_reg(16'h21ff);
        rd_chk(5'h00, 16'h2180);
        chk1(rate, 1'b1);
        chk1(fdx, 1'b1);
        chk1(mon[0], 1'b0);
        wr_reg(16'h3300);
        wait_bit(1, 1'b1, 3);
        wait_bit(1, 1'b0, 1);
        rd_chk(5'h00, 16'h3100);
        chk1(rate, 1'b0);
        chk1(fdx, 1'b0);
        wr_reg(16'h4180);
        go = 1'b1;
        wait_bit(2, 1'b1, 256);
        wait_bit(3, 1'b1, 256);
        chk1(ltxe | lrxe, 1'b0);
        go = 1'b0;
        wait_bit(3, 1'b0, 4);
        wr_reg(16'h4000);
        go = 1'b1;
        wait_bit(2, 1'b1, 256);
        chk1(mon[3], 1'b0);
        go = 1'b0;
        jab = 1'b1;
        wr_reg(16'h0400);
        jab = 1'b0;
        wait_bit(5, 1'b1, 3);
        wait_bit(6, 1'b1, 3);
        wr_reg(16'h0800);
        wait_bit(6, 1'b0, 3);
        chk1(ltri, 1'b1);
        rd_chk(5'h00, 16'h0800);
        jab = 1'b1;
        step(1);
        jab = 1'b0;
        chk1(mon[6], 1'b1);
        srd = 1'b1;
        step(1);
        srd = 1'b0;
        chk1(mon[6], 1'b0);
        chk1(llo, 1'b1);
        wr_reg(16'h8000);
        wait_bit(4, 1'b1, 3);
        rd_chk(5'h00, 16'h8000);
        wr_reg(16'h0000);
        wait_bit(4, 1'b0, 60);
        chk1(llo, 1'b0);
        rd_chk(5'h00, 16'h3400);
        hws  = 1'b0;
        strp = 3'h1;
        wait_bit(0, 1'b0, 6);
        step(2);
        chk1(rate, 1'b0);
        chk1(fdx, 1'b1);
        pad  = 5'h05;
        rstn = 1'b0;
        step(16);
        rstn = 1'b1;
        rd_chk(5'h00, 16'h3000);
        chk1(mon[5], 1'b0);
        report_and_stop();
    end
endmodule : tb_top
